// File: spc_ctrl.sv
// Control, pin steering and interrupt logic of the serial interface
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
module spc_ctrl (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   // Register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // Shift engine
   input  wire logic              xfer_done,
   input  wire logic              xfer_busy,
   input  wire logic              sck_drive,
   input  wire logic              mosi_drive,
   input  wire logic              miso_drive,
   output spc_pkg::spc_cfg_t      cfg,
   output logic                   half_tick,
   output logic [3:0]             pin_rx,
   // Port D general-purpose side, bits 5..2
   input  wire logic [3:0]        gp_data,
   // Port D pins 5..2
   input  wire logic [3:0]        pd_in,
   output spc_pkg::spc_pins_t     pd_drv,
   // Interrupt
   input  wire logic              cpu_irq_mask,
   output logic                   irq
);

   // Register state
   logic [7:0]                    ctrl_q;
   logic [7:0]                    ctrl_d;
   logic [7:0]                    system_options_two_q;
   logic [7:0]                    system_options_two_d;
   logic [7:0]                    port_d_direction_q;
   logic [7:0]                    port_d_direction_d;
   logic [spc_pkg::IRQ_W-1:0]     istat_q;
   logic [spc_pkg::IRQ_W-1:0]     istat_d;
   logic [spc_pkg::IRQ_W-1:0]     imask_q;
   logic [spc_pkg::IRQ_W-1:0]     imask_d;
   logic [7:0]                    rdata_q;
   logic [7:0]                    rdata_d;
   // Pin state
   logic [3:0]                    meta_q;
   logic [3:0]                    sync_q;
   spc_pkg::spc_pins_t            drv_q;
   spc_pkg::spc_pins_t            drv_d;
   // Decodes
   logic                          wr_ctrl;
   logic                          wr_system_options_two;
   logic                          wr_port_d_direction;
   logic                          wr_imask;
   logic                          rd_istat;
   logic                          sys_en;
   logic                          is_master;
   logic                          open_drain;
   logic                          fault;
   logic [2:0]                    rate;
   logic [3:0]                    ddr_spi;

   assign wr_ctrl  = reg_wr && (reg_addr == spc_pkg::OFF_CTRL);
   assign wr_system_options_two  = reg_wr && (reg_addr == spc_pkg::OFF_SYSTEM_OPTIONS_TWO);
   assign wr_port_d_direction  = reg_wr && (reg_addr == spc_pkg::OFF_PORT_D_DIRECTION);
   assign wr_imask = reg_wr && (reg_addr == spc_pkg::OFF_IMASK);
   assign rd_istat = reg_rd && (reg_addr == spc_pkg::OFF_ISTAT);

   assign sys_en     = ctrl_q[spc_pkg::CTL_SYS_EN];
   assign is_master  = ctrl_q[spc_pkg::CTL_MASTER];
   assign open_drain = ctrl_q[spc_pkg::CTL_OPEN_DRAIN];
   assign ddr_spi    = port_d_direction_q[spc_pkg::DDR_SPI_MSB:spc_pkg::DDR_SPI_LSB];
   // top rate bit from options two
   assign rate = {system_options_two_q[spc_pkg::SYSTEM_OPTIONS_TWO_RATE_EXT],
                  ctrl_q[spc_pkg::CTL_RATE_HI],
                  ctrl_q[spc_pkg::CTL_RATE_LO]};

   // fault input only with direction clear
   assign fault = sys_en && is_master && !ddr_spi[spc_pkg::PIN_SS]
                  && !sync_q[spc_pkg::PIN_SS];

   // polarity and phase to the shifter
   assign cfg = '{enable: sys_en,
                  master: is_master,
                  clock_idle_polarity:   ctrl_q[spc_pkg::CTL_CLOCK_IDLE_POLARITY],
                  clock_phase_select:   ctrl_q[spc_pkg::CTL_CLOCK_PHASE_SELECT]};

   // Register next values
   always_comb begin
      ctrl_d  = ctrl_q;
      system_options_two_d  = system_options_two_q;
      port_d_direction_d  = port_d_direction_q;
      imask_d = imask_q;
      istat_d = istat_q;
      if (wr_ctrl) begin
         ctrl_d = reg_wdata;
      end
      if (wr_system_options_two) begin
         system_options_two_d = reg_wdata;
      end
      if (wr_port_d_direction) begin
         port_d_direction_d = reg_wdata;
      end
      if (wr_imask) begin
         imask_d = reg_wdata[spc_pkg::IRQ_W-1:0];
      end
      if (fault) begin
         ctrl_d[spc_pkg::CTL_MASTER] = 1'b0;
         port_d_direction_d[spc_pkg::DDR_SPI_MSB:spc_pkg::DDR_SPI_LSB] = 4'h0;
      end
      // Read clears; a new event in that cycle still lands
      if (rd_istat) begin
         istat_d = '0;
      end
      if (xfer_done) begin
         istat_d[spc_pkg::IRQ_DONE] = 1'b1;
      end
      if (fault) begin
         istat_d[spc_pkg::IRQ_FAULT] = 1'b1;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            spc_pkg::OFF_CTRL:  rdata_d = ctrl_q;
            spc_pkg::OFF_SYSTEM_OPTIONS_TWO:  rdata_d = system_options_two_q;
            spc_pkg::OFF_PORT_D_DIRECTION:  rdata_d = port_d_direction_q;
            spc_pkg::OFF_ISTAT: rdata_d = {6'h00, istat_q};
            spc_pkg::OFF_IMASK: rdata_d = {6'h00, imask_q};
            default:            rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_q  <= spc_pkg::CTRL_RESET;
         system_options_two_q  <= spc_pkg::SYSTEM_OPTIONS_TWO_RESET;
         port_d_direction_q  <= spc_pkg::PORT_D_DIRECTION_RESET;
         istat_q <= spc_pkg::IRQ_RESET;
         imask_q <= spc_pkg::IRQ_RESET;
         rdata_q <= 8'h00;
      end else if (ce) begin
         ctrl_q  <= ctrl_d;
         system_options_two_q  <= system_options_two_d;
         port_d_direction_q  <= port_d_direction_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // unmasked sticky event raises the line
   // gated by enable bit and CPU mask
   assign irq = ctrl_q[spc_pkg::CTL_IRQ_EN] && !cpu_irq_mask
                && |(istat_q & imask_q);

   // Pin next values
   always_comb begin
      drv_d = '{out: gp_data, oe: ddr_spi};
      if (sys_en) begin
         drv_d.oe  = 4'h0;
         drv_d.out = 4'h0;
         if (is_master) begin
            // outputs drive only with direction set
            // clock rests at polarity when idle
            drv_d.out[spc_pkg::PIN_MOSI] = mosi_drive;
            drv_d.out[spc_pkg::PIN_SCK]  = xfer_busy ? sck_drive
                                           : ctrl_q[spc_pkg::CTL_CLOCK_IDLE_POLARITY];
            drv_d.oe[spc_pkg::PIN_MOSI]  = ddr_spi[spc_pkg::PIN_MOSI];
            drv_d.oe[spc_pkg::PIN_SCK]   = ddr_spi[spc_pkg::PIN_SCK];
            drv_d.out[spc_pkg::PIN_SS]   = gp_data[spc_pkg::PIN_SS];
            drv_d.oe[spc_pkg::PIN_SS]    = ddr_spi[spc_pkg::PIN_SS];
         end else begin
            // Unselected slave keeps its data line released
            drv_d.out[spc_pkg::PIN_MISO] = miso_drive;
            drv_d.oe[spc_pkg::PIN_MISO]  = ddr_spi[spc_pkg::PIN_MISO]
                                           && !sync_q[spc_pkg::PIN_SS];
         end
      end
      if (open_drain) begin
         drv_d.oe  = drv_d.oe & ~drv_d.out;
         drv_d.out = 4'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
         drv_q  <= '0;
      end else if (ce) begin
         meta_q <= pd_in;
         sync_q <= meta_q;
         drv_q  <= drv_d;
      end
   end

   assign pd_drv = drv_q;
   assign pin_rx = sync_q;

   // slave role never runs the divider
   spc_rate_div u_rate_div (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .ce        (ce),
      .run       (sys_en && is_master && xfer_busy),
      .rate      (rate),
      .half_tick (half_tick)
   );

   a_irq_gating: assert property (
      @(posedge clk_sys) disable iff (rst)
      irq |-> ctrl_q[spc_pkg::CTL_IRQ_EN] && !cpu_irq_mask)
      else $error("interrupt while disabled or masked");

   a_irq_on_done: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && xfer_done && !rd_istat ##1 imask_q[spc_pkg::IRQ_DONE]
      && ctrl_q[spc_pkg::CTL_IRQ_EN] && !cpu_irq_mask |-> irq)
      else $error("done event gave no interrupt");

   a_fault_clears: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && fault |=> !ctrl_q[spc_pkg::CTL_MASTER] && ddr_spi == 4'h0
      && istat_q[spc_pkg::IRQ_FAULT])
      else $error("mode fault did not clear role and directions");

   a_pins_released: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && !sys_en && !open_drain |=> pd_drv.oe == $past(ddr_spi)
      && pd_drv.out == $past(gp_data))
      else $error("disabled interface still steers pins");

   a_slave_inputs: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && sys_en && !is_master |=> pd_drv.oe[spc_pkg::PIN_SS:
      spc_pkg::PIN_MOSI] == 3'h0)
      else $error("slave drives an input pin");

   a_master_dir: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && sys_en && is_master && !ddr_spi[spc_pkg::PIN_SCK]
      |=> !pd_drv.oe[spc_pkg::PIN_SCK] && !pd_drv.oe[spc_pkg::PIN_MISO])
      else $error("master drives without direction bit");

   a_open_drain: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && open_drain |=> (pd_drv.oe & pd_drv.out) == 4'h0)
      else $error("open-drain pin drives high");

   a_sck_idle: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && sys_en && is_master && !xfer_busy && !open_drain
      && ddr_spi[spc_pkg::PIN_SCK]
      |=> pd_drv.oe[spc_pkg::PIN_SCK]
      && pd_drv.out[spc_pkg::PIN_SCK] == $past(cfg.clock_idle_polarity))
      else $error("idle clock not at polarity level");

   a_ctrl_readback: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && wr_ctrl && !fault ##1 ce && reg_rd
      && reg_addr == spc_pkg::OFF_CTRL
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("control register read back wrong");

   a_reset_vals: assert property (
      @(posedge clk_sys)
      rst |=> ctrl_q == spc_pkg::CTRL_RESET
      && !system_options_two_q[spc_pkg::SYSTEM_OPTIONS_TWO_RATE_EXT])
      else $error("control reset value wrong");

   a_rdata_idle: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");

   // Set wins over a clearing read in the same cycle
   a_done_sticky: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && xfer_done |=> istat_q[spc_pkg::IRQ_DONE])
      else $error("done event lost");

   a_slave_no_tick: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && !is_master |=> !half_tick)
      else $error("divider ticks in slave role");

   a_pd5_input: assert property (
      @(posedge clk_sys) disable iff (rst)
      ce && sys_en && is_master && !ddr_spi[spc_pkg::PIN_SS]
      |=> !pd_drv.oe[spc_pkg::PIN_SS])
      else $error("fault input pin is driven");

endmodule

// File: spc_peer.sv
// Far-side serial device model on port D pins 5..2
`timescale 1ns/1ns
module spc_peer (
   // Clock
   input  wire logic               clk_sys,
   // Block pin drive and select level
   input  wire spc_pkg::spc_pins_t pd_drv,
   input  wire logic               ss_n,
   // Resolved pin levels
   output logic [3:0]              pd_in
);
   logic [3:0] wig_q = 4'h5;

   // Released lines other than the select toggle so a stale value never reads as valid
   always @(posedge clk_sys) begin
      wig_q <= ~wig_q;
   end

   always_comb begin
      pd_in = wig_q;
      pd_in[3] = ss_n;
      for (int i = 0; i < 4; i++) begin
         if (pd_drv.oe[i]) begin
            pd_in[i] = pd_drv.out[i];
         end
      end
   end
endmodule

// File: spc_pkg.sv
// Constants, types and helpers for the serial interface control block
package spc_pkg;

   // Register port
   localparam int         ADDR_W     = 8;
   localparam int         DATA_W     = 8;
   localparam logic [7:0] OFF_CTRL   = 8'h28;
   localparam logic [7:0] OFF_SYSTEM_OPTIONS_TWO   = 8'h39;
   localparam logic [7:0] OFF_PORT_D_DIRECTION   = 8'h3a;
   localparam logic [7:0] OFF_ISTAT  = 8'h3c;
   localparam logic [7:0] OFF_IMASK  = 8'h3d;

   // Control register fields
   localparam int CTL_IRQ_EN     = 7;
   localparam int CTL_SYS_EN     = 6;
   localparam int CTL_OPEN_DRAIN = 5;
   localparam int CTL_MASTER     = 4;
   localparam int CTL_CLOCK_IDLE_POLARITY       = 3;
   localparam int CTL_CLOCK_PHASE_SELECT       = 2;
   localparam int CTL_RATE_HI    = 1;
   localparam int CTL_RATE_LO    = 0;
   localparam logic [7:0] CTRL_RESET = 8'h04;

   // Options two and direction register
   localparam int         SYSTEM_OPTIONS_TWO_RATE_EXT = 0;
   localparam logic [7:0] SYSTEM_OPTIONS_TWO_RESET    = 8'h00;
   localparam logic [7:0] PORT_D_DIRECTION_RESET    = 8'h00;
   localparam int         DDR_SPI_LSB   = 2;
   localparam int         DDR_SPI_MSB   = 5;

   // Interrupt status and mask layout
   localparam int         IRQ_DONE  = 0;
   localparam int         IRQ_FAULT = 1;
   localparam int         IRQ_W     = 2;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   // Serial pins inside the group of four (port D bits 2..5)
   localparam int PIN_MISO = 0;
   localparam int PIN_MOSI = 1;
   localparam int PIN_SCK  = 2;
   localparam int PIN_SS   = 3;
   localparam int PIN_N    = 4;

   // Bus clock divide ratios indexed by the three rate bits
   localparam int HALF_W = 7;
   localparam logic [7:0] DIV_TABLE [0:7] = '{
      8'h02, 8'h04, 8'h10, 8'h20, 8'h08, 8'h10, 8'h40, 8'h80};

   typedef struct packed {
      logic enable;
      logic master;
      logic clock_idle_polarity;
      logic clock_phase_select;
   } spc_cfg_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } spc_pins_t;

   // Half of the serial clock period, in bus clocks
   function automatic logic [HALF_W-1:0] spc_half(input logic [2:0] rate);
      logic [7:0] ratio;
      ratio = DIV_TABLE[rate];
      return ratio[7:1];
   endfunction

endpackage

// File: spc_rate_div.sv
// Serial clock rate divider producing half-period ticks
`timescale 1ns/1ns
module spc_rate_div (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       ce,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] rate,
   // Tick
   output logic            half_tick
);

   logic [spc_pkg::HALF_W-1:0] cnt_q;
   logic [spc_pkg::HALF_W-1:0] cnt_d;
   logic [spc_pkg::HALF_W-1:0] half;
   logic                       tick_q;
   logic                       tick_d;

   assign half      = spc_pkg::spc_half(rate);
   assign half_tick = tick_q;

   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!run) begin
         cnt_d = '0;
      end else if (cnt_q >= half - 1'b1) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (ce) begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   a_tick_needs_run: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(tick_q) |-> $past(run))
      else $error("rate tick without run");

   a_cnt_in_range: assert property (
      @(posedge clk_sys) disable iff (rst)
      run && ce |=> cnt_q < $past(half))
      else $error("divider count beyond half period");

endmodule

// File: spi_control_and_rate_select_tb.sv
// Self-checking bench for the serial control block
`timescale 1ns/1ns
module spi_control_and_rate_select_tb;
   logic               clk_sys = 1'b0;
   logic               rst = 1'b1;
   logic               ce = 1'b1;
   logic [7:0]         reg_addr = 8'h00;
   logic [7:0]         reg_wdata = 8'h00;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [7:0]         reg_rdata;
   logic               xfer_done = 1'b0;
   logic               xfer_busy = 1'b0;
   logic [2:0]         drv = 3'h0;
   logic [3:0]         gp_data = 4'h0;
   logic [3:0]         pd_in;
   logic [3:0]         pin_rx;
   logic               ss_n = 1'b1;
   logic               cpu_irq_mask = 1'b0;
   logic               irq;
   logic               half_tick;
   spc_pkg::spc_cfg_t  cfg;
   spc_pkg::spc_pins_t pd_drv;
   logic [7:0]         exp_q[$];
   logic               rd_d = 1'b0;
   int                 n_mismatch = 0;
   int                 num_checks = 0;
   int                 div_tab[8] = '{2, 4, 16, 32, 8, 16, 64, 128};

   always #5 clk_sys = ~clk_sys;

   spc_ctrl i_spc_ctrl (
      .clk_sys(clk_sys), .rst(rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .xfer_done(xfer_done), .xfer_busy(xfer_busy),
      .sck_drive(drv[2]), .mosi_drive(drv[1]), .miso_drive(drv[0]),
      .cfg(cfg), .half_tick(half_tick), .pin_rx(pin_rx),
      .gp_data(gp_data), .pd_in(pd_in), .pd_drv(pd_drv),
      .cpu_irq_mask(cpu_irq_mask), .irq(irq)
   );

   spc_peer i_spc_peer (
      .clk_sys(clk_sys), .pd_drv(pd_drv), .ss_n(ss_n), .pd_in(pd_in)
   );

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
      if (rd_d && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   // Write then read back with no gap between the strobes
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      exp_q.push_back(d);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic setio(input logic [3:0] g, input logic [2:0] d,
                        input logic b, input logic s);
      @(posedge clk_sys);
      gp_data <= g;
      drv <= d;
      xfer_busy <= b;
      ss_n <= s;
   endtask

   task automatic ic(input logic e);
      chk({7'h00, irq}, {7'h00, e});
   endtask

   // Pin drive settles three edges after a change
   task automatic pin(input logic [3:0] eo, input logic [3:0] eoe);
      wt(5);
      chk({pd_drv.out & pd_drv.oe, pd_drv.oe}, {eo & eoe, eoe});
   endtask

   task automatic gap(input int e);
      int n;
      n = 0;
      while (half_tick !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 300) n_mismatch++;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (half_tick !== 1'b1 && n < 300);
      chk(n[7:0], e[7:0]);
   endtask

   initial begin
      #900000;
      n_mismatch++;
      results();
   end

   initial begin
      logic [7:0] v;
      logic [3:0] g;
      logic [2:0] d;
      int         n;
      void'($urandom(32'h088e));
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(spc_pkg::OFF_CTRL, 8'h04);
      rd(spc_pkg::OFF_SYSTEM_OPTIONS_TWO, 8'h00);
      chk({4'h0, cfg}, 8'h01);
      rd(8'h50, 8'h00);
      // A write while the enable is low must not land
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(spc_pkg::OFF_CTRL, 8'h3b);
      @(posedge clk_sys);
      ce <= 1'b1;
      rd(spc_pkg::OFF_CTRL, 8'h04);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom) & 8'hbf;
         wrrd(spc_pkg::OFF_CTRL, v);
      end
      wr(spc_pkg::OFF_CTRL, 8'h80);
      wr(spc_pkg::OFF_IMASK, 8'h03);
      @(posedge clk_sys);
      xfer_done <= 1'b1;
      @(posedge clk_sys);
      xfer_done <= 1'b0;
      wt(1);
      ic(1'b1);
      @(posedge clk_sys);
      cpu_irq_mask <= 1'b1;
      wt(1);
      ic(1'b0);
      @(posedge clk_sys);
      cpu_irq_mask <= 1'b0;
      wr(spc_pkg::OFF_CTRL, 8'h00);
      wt(1);
      ic(1'b0);
      wr(spc_pkg::OFF_CTRL, 8'h80);
      wt(1);
      ic(1'b1);
      rd(spc_pkg::OFF_ISTAT, 8'h01);
      wt(2);
      ic(1'b0);
      g = 4'($urandom);
      d = 3'($urandom);
      wr(spc_pkg::OFF_PORT_D_DIRECTION, 8'h3c);
      wr(spc_pkg::OFF_CTRL, 8'h00);
      setio(g, d, 1'b0, 1'b1);
      pin(g, 4'hf);
      wr(spc_pkg::OFF_PORT_D_DIRECTION, 8'h38);
      wr(spc_pkg::OFF_CTRL, 8'h58);
      pin({g[3], 1'b1, d[1], 1'b0}, 4'he);
      chk({4'h0, cfg}, 8'h0e);
      wr(spc_pkg::OFF_CTRL, 8'h50);
      setio(g, d, 1'b1, 1'b1);
      pin({g[3], d[2], d[1], 1'b0}, 4'he);
      wr(spc_pkg::OFF_PORT_D_DIRECTION, 8'h20);
      pin({g[3], 3'h0}, 4'h8);
      wr(spc_pkg::OFF_PORT_D_DIRECTION, 8'h38);
      wr(spc_pkg::OFF_CTRL, 8'h78);
      setio(4'h8, 3'h0, 1'b0, 1'b1);
      pin(4'h0, 4'h2);
      wr(spc_pkg::OFF_PORT_D_DIRECTION, 8'h3c);
      wr(spc_pkg::OFF_CTRL, 8'h43);
      setio(g, d, 1'b1, 1'b0);
      pin({3'h0, d[0]}, 4'h1);
      chk({6'h00, pin_rx[3], pin_rx[0]}, {6'h00, 1'b0, d[0]});
      n = 0;
      repeat (70) begin
         @(posedge clk_sys);
         #1;
         if (half_tick !== 1'b0) n++;
      end
      chk(n[7:0], 8'h00);
      setio(g, d, 1'b0, 1'b1);
      pin(4'h0, 4'h0);
      rd(spc_pkg::OFF_ISTAT, 8'h00);
      wr(spc_pkg::OFF_PORT_D_DIRECTION, 8'h18);
      wr(spc_pkg::OFF_CTRL, 8'hd0);
      setio(g, d, 1'b0, 1'b0);
      wt(6);
      rd(spc_pkg::OFF_CTRL, 8'hc0);
      rd(spc_pkg::OFF_PORT_D_DIRECTION, 8'h00);
      wt(1);
      ic(1'b1);
      rd(spc_pkg::OFF_ISTAT, 8'h02);
      setio(g, d, 1'b0, 1'b1);
      wr(spc_pkg::OFF_PORT_D_DIRECTION, 8'h38);
      for (int r = 0; r < 8; r++) begin
         wr(spc_pkg::OFF_SYSTEM_OPTIONS_TWO, {7'h00, 1'(r >> 2)});
         wr(spc_pkg::OFF_CTRL, 8'h50 | 8'(r & 3));
         setio(g, d, 1'b1, 1'b1);
         gap(div_tab[r] / 2);
         setio(g, d, 1'b0, 1'b1);
      end
      // Second reset mid-run must clear the top rate bit again
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(spc_pkg::OFF_SYSTEM_OPTIONS_TWO, 8'h00);
      rd(spc_pkg::OFF_CTRL, 8'h04);
      wt(3);
      results();
   end
endmodule
